// ---- src/sync_tx_pkg.sv ----
// types shared by the transmitter files
// assumes nothing beyond a sv compiler
package sync_tx_pkg;
    typedef enum logic [1:0] {
        SHIFT_IDLE = 2'b00,
        SHIFT_LOAD = 2'b01,
        SHIFT_BUSY = 2'b10
    } shift_state_type;
endpackage

// ---- src/sync_tx_regs.svh ----
// register offsets, field positions and reset values of the synchronous slave transmitter
// assumes byte addresses on a 32-bit classic wishbone bus
`ifndef SYNC_TX_REGS_SVH
`define SYNC_TX_REGS_SVH

`define INTERRUPT_CONTROL_IDX       8'h0B
`define PERIPHERAL_FLAGS_1_IDX      8'h0C
`define RECEIVE_STATUS_CONTROL_IDX  8'h18
`define TRANSMIT_HOLDING_IDX        8'h19
`define PERIPHERAL_ENABLES_1_IDX    8'h8C
`define TRANSMIT_STATUS_CONTROL_IDX 8'h98
`define BAUD_RATE_DIVISOR_IDX       8'h99
`define SLEEP_CONTROL_IDX           8'hF0

`define GLOBAL_INT_BIT       7
`define PERIPH_INT_BIT       6
`define TRANSMIT_FLAG_BIT    4
`define SERIAL_PORT_EN_BIT   7
`define SINGLE_RX_EN_BIT     5
`define CONT_RX_EN_BIT       4
`define CLOCK_SOURCE_BIT     7
`define NINE_BIT_TX_BIT      6
`define TRANSMIT_EN_BIT      5
`define SYNC_MODE_BIT        4
`define SHIFT_EMPTY_BIT      1
`define NINTH_TX_BIT         0

`define INTERRUPT_CONTROL_RST       8'h00
`define RECEIVE_STATUS_CONTROL_RST  8'h00
`define TRANSMIT_STATUS_CONTROL_RST 8'h02
`define PERIPHERAL_ENABLES_1_RST    8'h00
`define BAUD_RATE_DIVISOR_RST       8'h00
`define INTERRUPT_VECTOR            16'h0004

`define FIFO_DEPTH 32
`define WORD_WIDTH 9
`endif

// ---- src/sync_tx_slave.sv ----
// synchronous slave transmitter: wishbone registers, fifo, shifter on external clock
// assumes shift clock and nothing else from the pins; bus on ref_clk
module sync_tx_slave
    import sync_tx_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        shift_clock_pin,
    output logic             serial_data_out,
    output logic             serial_data_oe_n,
    output logic             wake_request,
    output logic             interrupt_request
);
`include "sync_tx_regs.svh"

    logic [7:0]       interrupt_control_q;
    logic [7:0]       receive_status_control_q;
    logic [7:0]       peripheral_enables_1_q;
    logic [7:0]       transmit_status_control_q;
    logic [7:0]       baud_rate_divisor_q;
    logic             sleep_q;
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [2:0]       clk_sync_q;
    logic             clk_fall;
    logic [8:0]       shift_q;
    logic [3:0]       bits_q;
    logic             data_q;
    logic             oe_n_q;
    logic             wake_q;
    logic             irq_q;
    shift_state_type  state_q;
    logic [8:0]       fifo_in;
    logic             fifo_in_valid;
    logic             fifo_in_ready;
    logic [8:0]       fifo_out;
    logic             fifo_out_valid;
    logic             fifo_pop;
    logic             req;
    logic             wr;
    logic [7:0]       idx;
    logic             slave_mode;
    logic             tx_active;
    logic             transmit_flag;
    logic             shift_empty;
    logic [7:0]       rd_byte;

    // register indexes are byte-wide, so address is index times four
    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    assign slave_mode = !transmit_status_control_q[`CLOCK_SOURCE_BIT] &&
                        transmit_status_control_q[`SYNC_MODE_BIT];
    assign tx_active  = slave_mode && transmit_status_control_q[`TRANSMIT_EN_BIT] &&
                        receive_status_control_q[`SERIAL_PORT_EN_BIT];

    // ninth bit captured with the word, so later changes of it do not disturb a queued word
    assign fifo_in       = {transmit_status_control_q[`NINTH_TX_BIT], wb_dat_i[7:0]};
    assign fifo_in_valid = wr && (idx == `TRANSMIT_HOLDING_IDX) && tx_active;
    assign fifo_pop      = (state_q == SHIFT_LOAD);

    word_fifo #(
        .WIDTH (`WORD_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // flag is pure state of the holding queue: a write in the same cycle as a drain
    // leaves it clear, so no event is lost
    assign transmit_flag = !fifo_out_valid;
    assign shift_empty   = (state_q == SHIFT_IDLE);

    // bus slave: one wait state, ack drops the cycle after
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            `INTERRUPT_CONTROL_IDX:       rd_byte = interrupt_control_q;
            `PERIPHERAL_FLAGS_1_IDX:      rd_byte = {3'b000, transmit_flag, 4'h0};
            `RECEIVE_STATUS_CONTROL_IDX:  rd_byte = receive_status_control_q;
            `PERIPHERAL_ENABLES_1_IDX:    rd_byte = peripheral_enables_1_q;
            `TRANSMIT_STATUS_CONTROL_IDX: rd_byte = {transmit_status_control_q[7:2],
                                                     shift_empty,
                                                     transmit_status_control_q[0]};
            `BAUD_RATE_DIVISOR_IDX:       rd_byte = baud_rate_divisor_q;
            `SLEEP_CONTROL_IDX:           rd_byte = {7'h00, sleep_q};
            default:                      rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            interrupt_control_q       <= `INTERRUPT_CONTROL_RST;
            receive_status_control_q  <= `RECEIVE_STATUS_CONTROL_RST;
            peripheral_enables_1_q    <= `PERIPHERAL_ENABLES_1_RST;
            transmit_status_control_q <= `TRANSMIT_STATUS_CONTROL_RST;
            baud_rate_divisor_q       <= `BAUD_RATE_DIVISOR_RST;
        end else if (wr) begin
            unique case (idx)
                `INTERRUPT_CONTROL_IDX:       interrupt_control_q <= wb_dat_i[7:0];
                `RECEIVE_STATUS_CONTROL_IDX:  receive_status_control_q <= wb_dat_i[7:0];
                `PERIPHERAL_ENABLES_1_IDX:    peripheral_enables_1_q <= wb_dat_i[7:0];
                `TRANSMIT_STATUS_CONTROL_IDX: transmit_status_control_q <=
                    {wb_dat_i[7:4], 1'b0, wb_dat_i[2], 1'b0, wb_dat_i[0]};
                `BAUD_RATE_DIVISOR_IDX:       baud_rate_divisor_q <= wb_dat_i[7:0];
                default:                      ;
            endcase
        end
    end

    // sleep is set by software, cleared by wake; wake wins over a set
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sleep_q <= 1'b0;
        end else if (wake_q) begin
            sleep_q <= 1'b0;
        end else if (wr && idx == `SLEEP_CONTROL_IDX) begin
            sleep_q <= wb_dat_i[0];
        end
    end

    // shift clock from the pin: two sync flops, third for edge detect
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            // pin idles low; resetting to that level avoids a false fall
            clk_sync_q <= 3'b000;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], shift_clock_pin};
        end
    end
    assign clk_fall = clk_sync_q[2] && !clk_sync_q[1];

    // the shifter ignores sleep_q entirely, so sleep never stalls it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= SHIFT_IDLE;
            shift_q <= 9'h000;
            bits_q  <= 4'h0;
            data_q  <= 1'b1;
            oe_n_q  <= 1'b1;
        end else if (!tx_active) begin
            state_q <= SHIFT_IDLE;
            data_q  <= 1'b1;
            oe_n_q  <= 1'b1;
        end else begin
            unique case (state_q)
                SHIFT_IDLE: begin
                    if (fifo_out_valid) begin
                        state_q <= SHIFT_LOAD;
                    end
                end
                SHIFT_LOAD: begin
                    shift_q <= fifo_out;
                    bits_q  <= transmit_status_control_q[`NINE_BIT_TX_BIT] ? 4'd9 : 4'd8;
                    data_q  <= fifo_out[0];
                    oe_n_q  <= 1'b0;
                    state_q <= SHIFT_BUSY;
                end
                SHIFT_BUSY: begin
                    if (clk_fall) begin
                        if (bits_q == 4'h1 && fifo_out_valid) begin
                            state_q <= SHIFT_LOAD;
                        end else if (bits_q == 4'h1) begin
                            // release the line at idle level once the queue is dry
                            state_q <= SHIFT_IDLE;
                            data_q  <= 1'b1;
                            oe_n_q  <= 1'b1;
                        end else begin
                            shift_q <= {1'b0, shift_q[8:1]};
                            data_q  <= shift_q[1];
                        end
                        bits_q <= bits_q - 4'd1;
                    end
                end
                default: state_q <= SHIFT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q  <= transmit_flag && peripheral_enables_1_q[`TRANSMIT_FLAG_BIT] &&
                      interrupt_control_q[`GLOBAL_INT_BIT] &&
                      interrupt_control_q[`PERIPH_INT_BIT];
            wake_q <= sleep_q && transmit_flag &&
                      peripheral_enables_1_q[`TRANSMIT_FLAG_BIT];
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = dat_q;
    assign serial_data_out   = data_q;
    assign serial_data_oe_n  = oe_n_q;
    assign wake_request      = wake_q;
    assign interrupt_request = irq_q;

    // fifo_in_ready unused by design: a write to a full queue is dropped
    logic unused_ok;
    assign unused_ok = fifo_in_ready;
endmodule

// ---- src/word_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
module word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;
    logic [AW-1:0]    rd_next;
    logic [WIDTH-1:0] head_q;

    // head word held in a register so read data comes from a flop
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    assign out_valid = (cnt_q != '0);
    assign rd_next   = pop ? rd_q + 1'b1 : rd_q;

    // bypass a word written into the slot that is about to become head
    always_ff @(posedge ref_clk) begin
        if (push && (wr_q == rd_next)) begin
            head_q <= in_data;
        end else begin
            head_q <= mem[rd_next];
        end
    end
    assign out_data  = head_q;
endmodule

// ---- testbench/sync_master_model.sv ----
// partner: external synchronous master that drives the shift clock
// assumes the slave moves data on falling edges; clock idles low
module sync_master_model (
    output logic      sclk,
    input  wire logic data,
    input  wire logic oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // stands still between frames
    initial sclk = 1'b0;
    task automatic frame(input int n, output logic [8:0] w);
        w = 9'h000;
        #7.3;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1; // external shift clock
            w[i] = oe_n ? 1'bx : data; // lsb first, undriven line reads unknown
            #62.5 sclk = 1'b0;
            #62.5;
        end
    endtask
endmodule

// ---- testbench/sync_tx_checker_sva.sv ----
// checker of the slave transmitter ports
// assumes it is bound into sync_tx_slave
module sync_tx_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        shift_clock_pin,
    input wire logic        serial_data_out,
    input wire logic        serial_data_oe_n,
    input wire logic        wake_request,
    input wire logic        interrupt_request
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [9:0] pin_q;
    logic [5:0] ack_q;
    logic       busy;
    logic       acked;
    // history wide enough to cover synchroniser plus load latency
    always_ff @(posedge ref_clk) pin_q <= nrst ? {pin_q[8:0], shift_clock_pin} : 10'h000;
    always_ff @(posedge ref_clk) ack_q <= nrst ? {ack_q[4:0], wb_ack_o} : 6'h00;
    assign busy  = (pin_q != 10'h000) && (pin_q != 10'h3FF);
    assign acked = |ack_q;
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack late");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_read_width; wb_dat_o[31:8] == 24'h000000; endproperty
    a_read_width: assert property (p_read_width) else $error("upper read bits set");
    property p_idle_level; serial_data_oe_n |-> serial_data_out; endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle data not high");
    property p_bit_hold;
        !serial_data_oe_n && $past(!serial_data_oe_n) && !busy |-> $stable(serial_data_out);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("data moved without clock");
    property p_release; $rose(serial_data_oe_n) |-> busy; endproperty
    a_release: assert property (p_release) else $error("release without clock");
    property p_start; $fell(serial_data_oe_n) |-> acked || busy; endproperty
    a_start: assert property (p_start) else $error("drive without cause");
    property p_wake_cause; $rose(wake_request) |-> acked || busy; endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
    property p_irq_cause; $rose(interrupt_request) |-> acked || busy; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_irq_clear; $fell(interrupt_request) |-> acked; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq fell without write");
    c_wake: cover property ($rose(wake_request));
    c_frame_end: cover property ($rose(serial_data_oe_n));
    c_flag_read: cover property (wb_ack_o && wb_dat_o[4]);
endmodule
bind sync_tx_slave sync_tx_checker sync_tx_checker_i (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .shift_clock_pin, .serial_data_out, .serial_data_oe_n,
    .wake_request, .interrupt_request);

// ---- testbench/sync_tx_slave_bench.sv ----
// testbench: wishbone master tasks and directed tests of the slave transmitter
// assumes the partner model drives the shift clock
module sync_tx_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack;
    logic        sclk;
    logic        sdo;
    logic        oe_n;
    logic        wake;
    logic        irq;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  lanes = 4'hF;
    logic        wake_seen = 1'b0;
    logic [31:0] q;
    logic [8:0]  w;
    int          errors = 0;
    int          total_checks = 0;
    localparam logic [15:0] RST [7] = '{16'h9802, 16'h0C10, 16'h8C00, 16'h9900,
                                        16'h0B00, 16'h1800, 16'h4000};
    sync_tx_slave sync_tx_slave_i (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .shift_clock_pin(sclk), .serial_data_out(sdo),
        .serial_data_oe_n(oe_n), .wake_request(wake), .interrupt_request(irq));
    sync_master_model sync_master_model_i (.sclk(sclk), .data(sdo), .oe_n(oe_n));
    // wake is a short pulse: sleep is cleared by it, so remember that it came
    always @(posedge ref_clk) begin
        if (wake === 1'b1) wake_seen <= 1'b1;
    end
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= wr;
        sel <= lanes;
        adr <= {22'h0, a, 2'b00};
        dat <= {24'h0, d};
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #150us;
        errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) rd(RST[i][15:8], RST[i][7:0]);
        wr(8'h99, 8'h5A);
        rd(8'h99, 8'h5A);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        lanes = 4'hE;
        wr(8'h99, 8'hA5); // lane 0 clear: write refused
        lanes = 4'hF;
        rd(8'h99, 8'h5A);
        wr(8'h19, 8'h11);
        rd(8'h0C, 8'h10);
        wr(8'h18, 8'h80); // port on, both receive enables clear
        wr(8'h98, 8'hB0);
        wr(8'h19, 8'h22);
        rd(8'h0C, 8'h10);
        chk(oe_n, 1);
        $display("test registers done");
        wr(8'h98, 8'h30);
        wr(8'h8C, 8'h10);
        wr(8'h0B, 8'hC0);
        @(posedge ref_clk); // irq registers one cycle after the enables land
        chk(irq, 1);
        wr(8'h19, 8'hA5);
        wr(8'h19, 8'h3C);
        wr(8'hF0, 8'h01);
        repeat (4) @(posedge ref_clk);
        rd(8'h0C, 8'h00);
        rd(8'h98, 8'h30);
        chk(wake, 0);
        sync_master_model_i.frame(8, w);
        chk(w, 9'h0A5);
        repeat (10) @(posedge ref_clk);
        rd(8'h0C, 8'h10);
        chk(wake_seen, 1);
        rd(8'hF0, 8'h00);
        sync_master_model_i.frame(8, w);
        chk(w, 9'h03C);
        $display("test sleep done");
        wr(8'h98, 8'h71);
        wr(8'h19, 8'h5A);
        repeat (4) @(posedge ref_clk);
        sync_master_model_i.frame(9, w);
        chk(w, 9'h15A);
        $display("test nine bit done");
        // shifter takes one word, so the queue refuses the 34th
        wr(8'h98, 8'h30);
        for (int i = 0; i < 34; i++) wr(8'h19, 8'(i));
        rd(8'h0C, 8'h00);
        for (int i = 0; i < 33; i++) begin
            sync_master_model_i.frame(8, w);
            chk(w, 32'(i));
        end
        repeat (10) @(posedge ref_clk);
        chk(oe_n, 1);
        rd(8'h0C, 8'h10);
        rd(8'h98, 8'h32);
        $display("test queue done");
        final_report();
    end
endmodule
